// ---- cbi_asserts.sv ----
// link checks between master end and module end
`timescale 1ns/1ps
module cbi_asserts #(
    parameter int unsigned REFRESH_CYCLES = 8    // device refresh period
) (
    input logic             i_clk_sys,     // system clock
    input logic             i_rst_b,       // async reset, low
    input logic [1:0][12:0] axis_cmd,      // axis command bits
    input logic [2:0]       module_cmd,    // module command bits
    input logic [1:0][7:0]  axis_stat,     // axis status bits
    input logic [1:0][15:0] err_num,       // error numbers
    input logic [1:0][15:0] warn_num,      // warning numbers
    input logic             init_set_done  // init setting complete
);
    // a change waits up to one refresh, then two cycles more; two spare
    localparam int MAX_LAT = REFRESH_CYCLES + 4;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    err_reset_one_a: assert property ($rose(axis_cmd[0][5]) && axis_stat[0][0] |->
        ##[1:MAX_LAT] !axis_stat[0][0] && err_num[0] == 16'h0000 && warn_num[0] == 16'h0000)
        else $error("axis one error reset left error data");
    err_reset_two_a: assert property ($rose(axis_cmd[1][5]) && axis_stat[1][0] |->
        ##[1:MAX_LAT] !axis_stat[1][0] && err_num[1] == 16'h0000)
        else $error("axis two error reset left error data");
    aux_off_a: assert property ($rose(axis_cmd[0][7]) |-> ##[1:MAX_LAT] !axis_stat[0][2])
        else $error("aux code active not cleared");
    zret_clear_a: assert property ($rose(axis_cmd[0][11]) |-> ##[1:MAX_LAT] !axis_stat[0][3])
        else $error("zero return request not cleared");
    init_done_drop_a: assert property ($fell(module_cmd[2]) |-> ##[1:MAX_LAT] !init_set_done)
        else $error("init setting complete stayed high");
    abs_ack_a: assert property (axis_stat[0][4] |-> ##[0:2] !axis_cmd[0][3])
        else $error("abs request stayed high after acceptance");
    dev_clr_ack_a: assert property (axis_stat[0][5] |-> ##[0:2] !axis_cmd[0][4])
        else $error("deviation clear stayed high after acceptance");
    busy_warn_a: assert property ($rose(axis_stat[0][1]) |->
        ##[0:1] warn_num[0] == cbi_pkg::WARN_START_DURING_OP)
        else $error("warning number wrong for start during operation");
endmodule

// ---- cbi_device.sv ----
// positioning module end: command bit interpreter
`timescale 1ns/1ps
// Summary of operation
// - reverse jog while held, decelerate on release
// - master raises servo enable for amplifier
// - absolute transfer mode only for maintenance
// - absolute request held; low means accepted
// - deviation clear held; low means accepted
// - error reset clears error and warning data, except while starting
// - reset moves error to standby, not starting
// - error reset acts on rising edge only
// - restart from stop on rising edge
// - aux code off edge clears active bit
// - edge commands refreshed once per period
// - new speed first, change on edge
// - changeover input honoured only when enabled
// - manual pulse generator only when enabled
// - zero-return clear edge clears request bit
// - external start accepted only when enabled
// - init request leads to processing complete
// - master raises init request on change
// - setting complete rises, falls with request
// - start while busy gives warning 100
module cbi_device #(
    parameter int unsigned REFRESH_CYCLES = cbi_pkg::REFRESH_CYCLES
) (
    input  wire logic                       i_clk_sys,        // system clock
    input  wire logic                       i_rst_b,          // async reset, low
    cbi_link_if.dev                         link,             // link to master
    input  wire logic [1:0]                 i_error_event,    // axis error pulse
    input  wire logic [1:0][15:0]           i_error_code,     // error number
    input  wire logic [1:0]                 i_aux_code_set,   // aux code issued
    input  wire logic [1:0]                 i_zero_ret_set,   // zero return needed
    input  wire logic [1:0]                 i_motion_done,    // axis came to rest
    input  wire logic [1:0]                 i_stop_event,     // positioning stopped
    input  wire logic [1:0]                 i_abs_ack,        // abs request taken
    input  wire logic [1:0]                 i_dev_clr_ack,    // clear request taken
    input  wire logic [1:0]                 i_spo_change,     // changeover input
    input  wire logic                       i_ext_start,      // external start pulse
    input  wire logic                       i_init_complete,  // init setting done
    output logic      [1:0]                 o_jog_rev,        // reverse jog running
    output logic      [1:0]                 o_decel,          // decelerating
    output logic      [1:0]                 o_start_pulse,    // positioning start
    output logic      [1:0]                 o_restart_pulse,  // restart from stop
    output logic      [1:0]                 o_servo_on,       // servo amplifier on
    output logic      [1:0]                 o_abs_mode,       // abs transfer mode
    output logic      [1:0]                 o_abs_data_req,   // abs data wanted
    output logic      [1:0]                 o_dev_clr_req,    // deviation clear
    output logic      [1:0]                 o_speed_apply,    // speed change pulse
    output logic      [1:0][31:0]           o_speed_value,    // speed to apply
    output logic      [1:0]                 o_spo_change,     // gated changeover
    output logic      [1:0]                 o_mpg_enable,     // pulse generator ok
    output logic                            o_init_setting,   // init setting pulse
    output logic                            o_remote_ready    // ready to position
);
    localparam int NA = cbi_pkg::NUM_AXES;
    localparam logic [cbi_pkg::CNT_W-1:0] CNT_LAST = cbi_pkg::CNT_W'(REFRESH_CYCLES - 1);

    typedef struct packed {
        logic [cbi_pkg::CNT_W-1:0]                 cnt;
        logic                                      tick;
        logic [NA-1:0][cbi_pkg::CMD_W-1:0]         cmd;
        logic [NA-1:0][cbi_pkg::CMD_W-1:0]         pulse;
        logic [cbi_pkg::MOD_W-1:0]                 mods;
        logic                                      init_pulse;
        logic                                      init_done;
        logic [NA-1:0][cbi_pkg::SPEED_W-1:0]       speed;
        cbi_pkg::cbi_op_type [NA-1:0]              op;
        logic [NA-1:0]                             err;
        logic [NA-1:0]                             warn;
        logic [NA-1:0]                             aux;
        logic [NA-1:0]                             zret;
        logic [NA-1:0]                             abs_ack;
        logic [NA-1:0]                             clr_ack;
        logic [NA-1:0][cbi_pkg::CODE_W-1:0]        err_num;
        logic [NA-1:0][cbi_pkg::CODE_W-1:0]        warn_num;
        logic [NA-1:0]                             start;
        logic [NA-1:0]                             restart;
        logic [NA-1:0]                             spd_apply;
        logic [NA-1:0][cbi_pkg::SPEED_W-1:0]       spd_out;
    } cbi_dev_state_type;

    cbi_dev_state_type s_q;
    cbi_dev_state_type s_d;

    // busy covers every state in which the axis is already moving
    function automatic logic is_busy(input cbi_pkg::cbi_op_type op);
        is_busy = (op == cbi_pkg::OP_STARTING) || (op == cbi_pkg::OP_BUSY) ||
                  (op == cbi_pkg::OP_JOG) || (op == cbi_pkg::OP_DECEL);
    endfunction

    logic ext_go;

    assign ext_go = i_ext_start & s_q.mods[cbi_pkg::MOD_EXT_START_EN];

    // next state
    always_comb begin
        logic go;
        go = 1'b0;
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.init_pulse = 1'b0;
        s_d.start = '0;
        s_d.restart = '0;
        s_d.spd_apply = '0;
        s_d.pulse = '0;
        if (s_q.cnt == CNT_LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        if (s_q.tick) begin
            s_d.pulse = link.axis_cmd & ~s_q.cmd;
            s_d.init_pulse = link.module_cmd[cbi_pkg::MOD_INIT_SETTING_REQUEST] &
                             ~s_q.mods[cbi_pkg::MOD_INIT_SETTING_REQUEST];
            s_d.cmd = link.axis_cmd;
            s_d.mods = link.module_cmd;
            s_d.speed = link.new_speed;
        end
        if (!s_q.mods[cbi_pkg::MOD_INIT_SETTING_REQUEST]) begin
            s_d.init_done = 1'b0;
        end
        if (i_init_complete && s_q.mods[cbi_pkg::MOD_INIT_SETTING_REQUEST]) begin
            s_d.init_done = 1'b1;
        end
        for (int a = 0; a < NA; a++) begin
            s_d.abs_ack[a] = i_abs_ack[a];
            s_d.clr_ack[a] = i_dev_clr_ack[a];
            go = s_q.pulse[a][cbi_pkg::CMD_POS_START] | ext_go;
            if (s_q.pulse[a][cbi_pkg::CMD_AUX_OFF]) begin
                s_d.aux[a] = 1'b0;
            end
            if (i_aux_code_set[a]) begin
                s_d.aux[a] = 1'b1;
            end
            if (s_q.pulse[a][cbi_pkg::CMD_ZRET_CLR]) begin
                s_d.zret[a] = 1'b0;
            end
            if (i_zero_ret_set[a]) begin
                s_d.zret[a] = 1'b1;
            end
            if (s_q.pulse[a][cbi_pkg::CMD_ERR_RST] && s_q.op[a] != cbi_pkg::OP_STARTING) begin
                s_d.err[a] = 1'b0;
                s_d.warn[a] = 1'b0;
                s_d.err_num[a] = '0;
                s_d.warn_num[a] = '0;
                if (s_q.op[a] == cbi_pkg::OP_ERROR) begin
                    s_d.op[a] = cbi_pkg::OP_STANDBY;
                end
            end
            if (go && is_busy(s_q.op[a])) begin
                s_d.warn[a] = 1'b1;
                s_d.warn_num[a] = cbi_pkg::WARN_START_DURING_OP;
            end
            case (s_q.op[a])
                cbi_pkg::OP_STANDBY: begin
                    if (go) begin
                        s_d.op[a] = cbi_pkg::OP_STARTING;
                        s_d.start[a] = 1'b1;
                    end else if (s_q.cmd[a][cbi_pkg::CMD_REV_JOG]) begin
                        s_d.op[a] = cbi_pkg::OP_JOG;
                    end
                end
                cbi_pkg::OP_STARTING: s_d.op[a] = cbi_pkg::OP_BUSY;
                cbi_pkg::OP_BUSY: begin
                    if (i_stop_event[a]) begin
                        s_d.op[a] = cbi_pkg::OP_STOPPED;
                    end else if (i_motion_done[a]) begin
                        s_d.op[a] = cbi_pkg::OP_STANDBY;
                    end
                    if (s_q.pulse[a][cbi_pkg::CMD_SPD_CHG]) begin
                        s_d.spd_apply[a] = 1'b1;
                        s_d.spd_out[a] = s_q.speed[a];
                    end
                end
                cbi_pkg::OP_STOPPED: begin
                    if (s_q.pulse[a][cbi_pkg::CMD_RESTART]) begin
                        s_d.op[a] = cbi_pkg::OP_BUSY;
                        s_d.restart[a] = 1'b1;
                    end
                end
                cbi_pkg::OP_JOG: begin
                    if (!s_q.cmd[a][cbi_pkg::CMD_REV_JOG]) begin
                        s_d.op[a] = cbi_pkg::OP_DECEL;
                    end
                end
                cbi_pkg::OP_DECEL: begin
                    if (i_motion_done[a]) begin
                        s_d.op[a] = cbi_pkg::OP_STANDBY;
                    end
                end
                cbi_pkg::OP_ERROR: ;
                default: s_d.op[a] = cbi_pkg::OP_STANDBY;
            endcase
            // an error beats every other move, including a reset in the same cycle
            if (i_error_event[a]) begin
                s_d.op[a] = cbi_pkg::OP_ERROR;
                s_d.err[a] = 1'b1;
                s_d.err_num[a] = i_error_code[a];
            end
        end
    end

    // state register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // per-axis outputs
    for (genvar g = 0; g < NA; g++) begin : g_axis
        assign o_jog_rev[g]       = (s_q.op[g] == cbi_pkg::OP_JOG);
        assign o_decel[g]         = (s_q.op[g] == cbi_pkg::OP_DECEL);
        assign o_start_pulse[g]   = s_q.start[g];
        assign o_restart_pulse[g] = s_q.restart[g];
        assign o_servo_on[g]      = s_q.cmd[g][cbi_pkg::CMD_SERVO_ON];
        assign o_abs_mode[g]      = s_q.cmd[g][cbi_pkg::CMD_ABS_MODE];
        // request only counts in abs mode
        assign o_abs_data_req[g]  = s_q.cmd[g][cbi_pkg::CMD_ABS_MODE] &
                                    s_q.cmd[g][cbi_pkg::CMD_ABS_REQ];
        assign o_dev_clr_req[g]   = s_q.cmd[g][cbi_pkg::CMD_DEV_CLR];
        assign o_speed_apply[g]   = s_q.spd_apply[g];
        assign o_speed_value[g]   = s_q.spd_out[g];
        assign o_spo_change[g]    = i_spo_change[g] & s_q.cmd[g][cbi_pkg::CMD_SPO_EN];
        assign o_mpg_enable[g]    = s_q.cmd[g][cbi_pkg::CMD_MPG_EN];
        assign link.axis_stat[g]  = {s_q.op[g] == cbi_pkg::OP_STOPPED, is_busy(s_q.op[g]),
                                     s_q.clr_ack[g], s_q.abs_ack[g], s_q.zret[g],
                                     s_q.aux[g], s_q.warn[g], s_q.err[g]};
    end

    // module-level outputs
    assign link.err_num      = s_q.err_num;
    assign link.warn_num     = s_q.warn_num;
    assign link.init_set_done = s_q.init_done;
    assign o_init_setting    = s_q.init_pulse;
    assign o_remote_ready    = s_q.mods[cbi_pkg::MOD_INIT_PROCESSING_DONE] &
                               ~s_q.mods[cbi_pkg::MOD_INIT_SETTING_REQUEST];
endmodule

// ---- cbi_link_if.sv ----
// link between network master end and positioning module end
`timescale 1ns/1ps
interface cbi_link_if;
    logic [cbi_pkg::NUM_AXES-1:0][cbi_pkg::CMD_W-1:0]   axis_cmd;
    logic [cbi_pkg::MOD_W-1:0]                          module_cmd;
    logic [cbi_pkg::NUM_AXES-1:0][cbi_pkg::SPEED_W-1:0] new_speed;
    logic [cbi_pkg::NUM_AXES-1:0][cbi_pkg::STAT_W-1:0]  axis_stat;
    logic [cbi_pkg::NUM_AXES-1:0][cbi_pkg::CODE_W-1:0]  err_num;
    logic [cbi_pkg::NUM_AXES-1:0][cbi_pkg::CODE_W-1:0]  warn_num;
    logic                                               init_set_done;

    modport dev (
        input  axis_cmd, module_cmd, new_speed,
        output axis_stat, err_num, warn_num, init_set_done
    );
    modport mst (
        output axis_cmd, module_cmd, new_speed,
        input  axis_stat, err_num, warn_num, init_set_done
    );
endinterface

// ---- cbi_master.sv ----
// network master end: APB registers driving the command bits
`timescale 1ns/1ps
module cbi_master (
    input  wire logic                       i_clk_sys,   // system clock
    input  wire logic                       i_rst_b,     // async reset, low
    input  wire logic                       i_psel,      // APB select
    input  wire logic                       i_penable,   // APB enable
    input  wire logic                       i_pwrite,    // APB write
    input  wire logic [7:0]                 i_paddr,     // APB byte address
    input  wire logic [31:0]                i_pwdata,    // APB write data
    output logic      [31:0]                o_prdata,    // APB read data
    output logic                            o_pready,    // APB ready
    output logic                            o_pslverr,   // APB error
    cbi_link_if.mst                         link         // link to module
);
    localparam int NA = cbi_pkg::NUM_AXES;

    typedef struct packed {
        logic [NA-1:0][cbi_pkg::CMD_W-1:0]   cmd;
        logic [cbi_pkg::MOD_W-1:0]           mods;
        logic [NA-1:0][cbi_pkg::SPEED_W-1:0] speed;
        logic [cbi_pkg::DATA_W-1:0]          rdata;
        logic                                err;
    } cbi_mst_state_type;

    cbi_mst_state_type s_q;
    cbi_mst_state_type s_d;

    // address check shared by read and write paths
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr <= cbi_pkg::REG_MODULE_STAT) && (addr[1:0] == 2'h0);
    endfunction

    logic setup;
    logic access;

    assign setup  = i_psel & ~i_penable;
    assign access = i_psel & i_penable;

    // next state: read data and error are prepared in setup, writes land in access
    always_comb begin
        s_d = s_q;
        for (int a = 0; a < NA; a++) begin
            if (link.axis_stat[a][cbi_pkg::ST_ABS_ACK]) begin
                s_d.cmd[a][cbi_pkg::CMD_ABS_REQ] = 1'b0;
            end
            if (link.axis_stat[a][cbi_pkg::ST_DEV_CLR_ACK]) begin
                s_d.cmd[a][cbi_pkg::CMD_DEV_CLR] = 1'b0;
            end
        end
        if (setup) begin
            s_d.err = ~is_mapped(i_paddr);
            s_d.rdata = '0;
            case (i_paddr)
                cbi_pkg::REG_CMD_AXIS1:   s_d.rdata = 32'(s_q.cmd[0]);
                cbi_pkg::REG_CMD_AXIS2:   s_d.rdata = 32'(s_q.cmd[1]);
                cbi_pkg::REG_MODULE_CTRL: s_d.rdata = 32'(s_q.mods);
                cbi_pkg::REG_SPEED_AXIS1: s_d.rdata = s_q.speed[0];
                cbi_pkg::REG_SPEED_AXIS2: s_d.rdata = s_q.speed[1];
                cbi_pkg::REG_STAT_AXIS1:  s_d.rdata = 32'(link.axis_stat[0]);
                cbi_pkg::REG_STAT_AXIS2:  s_d.rdata = 32'(link.axis_stat[1]);
                cbi_pkg::REG_CODES_AXIS1: s_d.rdata = {link.err_num[0], link.warn_num[0]};
                cbi_pkg::REG_CODES_AXIS2: s_d.rdata = {link.err_num[1], link.warn_num[1]};
                cbi_pkg::REG_MODULE_STAT: s_d.rdata = 32'(link.init_set_done);
                default:                  s_d.rdata = '0;
            endcase
        end
        // software write wins over the acceptance drop in the same cycle
        if (access && i_pwrite) begin
            case (i_paddr)
                // abs mode left to maintenance software
                cbi_pkg::REG_CMD_AXIS1:   s_d.cmd[0] = i_pwdata[cbi_pkg::CMD_W-1:0];
                cbi_pkg::REG_CMD_AXIS2:   s_d.cmd[1] = i_pwdata[cbi_pkg::CMD_W-1:0];
                cbi_pkg::REG_MODULE_CTRL: s_d.mods = i_pwdata[cbi_pkg::MOD_W-1:0];
                // speed word before the change bit
                cbi_pkg::REG_SPEED_AXIS1: s_d.speed[0] = i_pwdata;
                cbi_pkg::REG_SPEED_AXIS2: s_d.speed[1] = i_pwdata;
                default:                  ;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // zero wait state slave
    assign o_pready  = 1'b1;
    assign o_prdata  = s_q.rdata;
    assign o_pslverr = s_q.err & access;

    // link drive
    assign link.axis_cmd   = s_q.cmd;
    assign link.module_cmd = s_q.mods;
    assign link.new_speed  = s_q.speed;
endmodule

// ---- cbi_pkg.sv ----
// shared constants and types for the axis command bit interpreter
package cbi_pkg;
    localparam int NUM_AXES = 2;
    localparam int CMD_W    = 13;
    localparam int MOD_W    = 3;
    localparam int STAT_W   = 8;
    localparam int CODE_W   = 16;
    localparam int SPEED_W  = 32;
    localparam int CNT_W    = 22;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;

    // per-axis command bit positions
    localparam int CMD_REV_JOG   = 0;
    localparam int CMD_SERVO_ON  = 1;
    localparam int CMD_ABS_MODE  = 2;
    localparam int CMD_ABS_REQ   = 3;
    localparam int CMD_DEV_CLR   = 4;
    localparam int CMD_ERR_RST   = 5;
    localparam int CMD_RESTART   = 6;
    localparam int CMD_AUX_OFF   = 7;
    localparam int CMD_SPD_CHG   = 8;
    localparam int CMD_SPO_EN    = 9;
    localparam int CMD_MPG_EN    = 10;
    localparam int CMD_ZRET_CLR  = 11;
    localparam int CMD_POS_START = 12;

    // module-level command bit positions
    localparam int MOD_EXT_START_EN         = 0;
    localparam int MOD_INIT_PROCESSING_DONE = 1;
    localparam int MOD_INIT_SETTING_REQUEST = 2;

    // per-axis status bit positions
    localparam int ST_ERR         = 0;
    localparam int ST_WARN        = 1;
    localparam int ST_AUX_ACTIVE  = 2;
    localparam int ST_ZRET_REQ    = 3;
    localparam int ST_ABS_ACK     = 4;
    localparam int ST_DEV_CLR_ACK = 5;
    localparam int ST_BUSY        = 6;
    localparam int ST_STOPPED     = 7;

    // refresh period of edge commands
    localparam int REFRESH_PERIOD_US = 56800;
    localparam int CLK_FREQ_MHZ      = 50;
    localparam int REFRESH_CYCLES    = REFRESH_PERIOD_US * CLK_FREQ_MHZ;

    localparam logic [CODE_W-1:0] WARN_START_DURING_OP = 16'h0064;

    // controller register map
    localparam logic [ADDR_W-1:0] REG_CMD_AXIS1    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CMD_AXIS2    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_MODULE_CTRL  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_SPEED_AXIS1  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_SPEED_AXIS2  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STAT_AXIS1   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STAT_AXIS2   = 8'h18;
    localparam logic [ADDR_W-1:0] REG_CODES_AXIS1  = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_CODES_AXIS2  = 8'h20;
    localparam logic [ADDR_W-1:0] REG_MODULE_STAT  = 8'h24;

    typedef enum logic [2:0] {
        OP_STANDBY,
        OP_STARTING,
        OP_BUSY,
        OP_STOPPED,
        OP_JOG,
        OP_DECEL,
        OP_ERROR
    } cbi_op_type;
endpackage

// ---- test_axis_command_bit_interpreter.sv ----
// self-checking bench joining master end and module end over the link
`timescale 1ns/1ps
module test_axis_command_bit_interpreter;
    localparam int unsigned RF = 8;  // short refresh keeps the run brief
    logic i_clk_sys, i_rst_b, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, perr, hit;
    logic i_init_complete, o_remote_ready, i_ext_start;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rdat, r;
    logic [1:0] i_error_event, i_aux_code_set, i_zero_ret_set, i_motion_done, i_abs_ack;
    logic [1:0] i_dev_clr_ack, i_spo_change, o_servo_on, o_abs_data_req, o_speed_apply;
    logic [1:0] o_spo_change, o_mpg_enable, i_stop_event;
    logic [1:0][15:0] i_error_code;
    logic [1:0][31:0] o_speed_value;
    int n_errors = 0;
    int compares = 0;
    integer seed = 54736;
    cbi_link_if link_i ();
    cbi_master cbi_master_i (.*, .link(link_i));
    cbi_device #(.REFRESH_CYCLES(RF)) cbi_device_i (.*, .link(link_i),
        .o_jog_rev(), .o_decel(), .o_start_pulse(), .o_restart_pulse(),
        .o_abs_mode(), .o_dev_clr_req(), .o_init_setting());
    cbi_asserts #(.REFRESH_CYCLES(RF)) cbi_asserts_i (.i_clk_sys, .i_rst_b,
        .axis_cmd(link_i.axis_cmd), .module_cmd(link_i.module_cmd),
        .axis_stat(link_i.axis_stat), .err_num(link_i.err_num), .warn_num(link_i.warn_num),
        .init_set_done(link_i.init_set_done));
    // free-running system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    task wt(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // one apb transfer; a read lands in rdat, the error flag in perr
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rdat = o_prdata;
        perr = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask
    task fire_err(input int a, input logic [15:0] c);
        @(posedge i_clk_sys);
        i_error_code[a] <= c;
        i_error_event[a] <= 1'b1;
        @(posedge i_clk_sys);
        i_error_event <= 2'b00;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task end_of_test;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        wt(6000);
        n_errors++;
        end_of_test;
    end
    // main sequence
    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_error_code} = '0;
        {i_error_event, i_aux_code_set, i_zero_ret_set, i_motion_done, i_abs_ack} = '0;
        {i_dev_clr_ack, i_spo_change, i_init_complete, i_stop_event} = '0;
        i_ext_start = 1'b1;  // held: only the enable bit gates it
        i_rst_b = 1'b0;
        wt(10);
        i_rst_b <= 1'b1;
        apb(1'b0, cbi_pkg::REG_STAT_AXIS1, '0);
        chk("status after reset", 32'h0, rdat);
        apb(1'b0, 8'h28, '0);
        chk("unmapped error", 32'h1, {31'h0, perr});
        for (int a = 0; a < 2; a++) begin
            r = $random(seed) | 32'h1;
            fire_err(a, r[15:0]);
            wt(2);
            apb(1'b0, cbi_pkg::REG_CODES_AXIS1 + 8'(4 * a), '0);
            chk("error number", {r[15:0], 16'h0}, rdat);
            apb(1'b1, cbi_pkg::REG_CMD_AXIS1 + 8'(4 * a), 32'h20);
            wt(RF + 2);
            apb(1'b0, cbi_pkg::REG_CODES_AXIS1 + 8'(4 * a), '0);
            chk("codes after reset", 32'h0, rdat);
            fire_err(a, r[15:0]);
            wt(RF + 2);
            apb(1'b0, cbi_pkg::REG_STAT_AXIS1 + 8'(4 * a), '0);
            chk("error on held bit", 32'h1, {31'h0, rdat[0]});
            apb(1'b1, cbi_pkg::REG_CMD_AXIS1 + 8'(4 * a), 32'h0);
            wt(RF + 2);
            apb(1'b1, cbi_pkg::REG_CMD_AXIS1 + 8'(4 * a), 32'h20);
            wt(RF + 2);
        end
        {i_aux_code_set, i_zero_ret_set} <= 4'hF;
        @(posedge i_clk_sys);
        {i_aux_code_set, i_zero_ret_set} <= 4'h0;
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h880);
        wt(RF + 2);
        apb(1'b0, cbi_pkg::REG_STAT_AXIS1, '0);
        chk("aux and zero return one", 32'h0, {30'h0, rdat[3:2]});
        apb(1'b0, cbi_pkg::REG_STAT_AXIS2, '0);
        chk("aux and zero return two", 32'h3, {30'h0, rdat[3:2]});
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h1C);
        wt(RF + 2);
        chk("abs data request", 32'h1, {31'h0, o_abs_data_req[0]});
        {i_abs_ack, i_dev_clr_ack} <= 4'h5;
        wt(4);
        apb(1'b0, cbi_pkg::REG_CMD_AXIS1, '0);
        chk("command after acks", 32'h4, rdat);
        {i_abs_ack, i_dev_clr_ack, i_spo_change} <= 6'h03;
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            apb(1'b1, cbi_pkg::REG_CMD_AXIS1, {21'h0, r[2:1], 7'h0, r[0], 1'b0});
            wt(RF + 2);
            chk("servo on", {31'h0, r[0]}, {31'h0, o_servo_on[0]});
            chk("changeover gate", {31'h0, r[1]}, {31'h0, o_spo_change[0]});
            chk("pulse generator", {31'h0, r[2]}, {31'h0, o_mpg_enable[0]});
        end
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h1000);
        wt(RF + 2);
        r = $random(seed);
        apb(1'b1, cbi_pkg::REG_SPEED_AXIS1, r);
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h1100);
        hit = 1'b0;
        repeat (RF + 3) begin
            @(posedge i_clk_sys);
            if (o_speed_apply[0] === 1'b1) hit = 1'b1;
        end
        chk("speed apply", 32'h1, {31'h0, hit});
        chk("speed value", r, o_speed_value[0]);
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h0);
        wt(RF + 2);
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h1000);
        wt(RF + 2);
        apb(1'b0, cbi_pkg::REG_CODES_AXIS1, '0);
        chk("start while busy", {16'h0, cbi_pkg::WARN_START_DURING_OP}, {16'h0, rdat[15:0]});
        i_stop_event <= 2'h1;
        @(posedge i_clk_sys);
        i_stop_event <= 2'h0;
        apb(1'b1, cbi_pkg::REG_CMD_AXIS1, 32'h40);
        wt(RF + 2);
        apb(1'b0, cbi_pkg::REG_STAT_AXIS1, '0);
        chk("restart", 32'h1, {30'h0, rdat[7:6]});
        apb(1'b1, cbi_pkg::REG_MODULE_CTRL, 32'h1);
        wt(RF + 2);
        apb(1'b0, cbi_pkg::REG_STAT_AXIS2, '0);
        chk("external start", 32'h1, {31'h0, rdat[6]});
        apb(1'b1, cbi_pkg::REG_MODULE_CTRL, 32'h4);
        wt(RF + 2);
        i_init_complete <= 1'b1;
        @(posedge i_clk_sys);
        i_init_complete <= 1'b0;
        wt(2);
        apb(1'b0, cbi_pkg::REG_MODULE_STAT, '0);
        chk("init setting done", 32'h1, {31'h0, rdat[0]});
        apb(1'b1, cbi_pkg::REG_MODULE_CTRL, 32'h2);
        wt(RF + 2);
        apb(1'b0, cbi_pkg::REG_MODULE_STAT, '0);
        chk("init done dropped", 32'h0, {31'h0, rdat[0]});
        chk("remote ready", 32'h1, {31'h0, o_remote_ready});
        end_of_test;
    end
endmodule
